// ### dspcp_core.sv
// serial frame receiver, update and clear control, alert output
`timescale 1ns/1ns
`default_nettype none
module dspcp_core
   import dspcp_pkg::*;
(
   // system clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   // serial link
   input wire logic sclk_in,
   input wire logic frame_sel_n_in,
   input wire logic serial_in_in,
   output logic serial_out_out,
   output logic serial_out_en_out,
   // mode levels
   input wire logic daisy_chain_en_in,
   input wire logic readback_en_in,
   // control pins
   input wire logic load_strobe_n_in,
   input wire logic clear_n_in,
   // fault detectors
   input wire dspcp_fault_type fault_in,
   // converter side
   output logic [15:0] dac_code_out,
   output logic [15:0] input_code_out,
   output logic out_clamp_out,
   output logic alert_n_out
);
   // link domain: everything here runs on the serial clock
   logic [4:0] bit_cnt, next_bit_cnt;
   logic [23:0] shift_reg, next_shift_reg;
   dspcp_frame_type word_hold, next_word_hold;
   logic cap_toggle, next_cap_toggle;
   logic so_bit, next_so_bit;
   logic daisy_m, daisy_s, rb_m, rb_s;

   // bit counter, held cleared while frame select is high
   always_comb begin
      next_bit_cnt = bit_cnt;
      if (bit_cnt != BIT_CNT_FULL) begin
         next_bit_cnt = bit_cnt + 1'b1;
      end
   end

   always_ff @(negedge sclk_in or negedge rst_n_in
      or posedge frame_sel_n_in) begin
      if (!rst_n_in) begin
         bit_cnt <= BIT_CNT_RESET;
      end else if (frame_sel_n_in) begin
         bit_cnt <= BIT_CNT_RESET;
      end else begin
         bit_cnt <= next_bit_cnt;
      end
   end

   // shift in on falling edges; capture the word at bit 24
   always_comb begin
      next_shift_reg = shift_reg;
      next_word_hold = word_hold;
      next_cap_toggle = cap_toggle;
      if (!frame_sel_n_in) begin
         next_shift_reg = {shift_reg[22:0], serial_in_in};
         if (bit_cnt == BIT_CNT_FULL - 5'h01) begin
            next_word_hold = next_shift_reg;
            next_cap_toggle = !cap_toggle;
         end
      end
   end

   always_ff @(negedge sclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         shift_reg <= WORD_RESET;
         word_hold <= WORD_RESET;
         cap_toggle <= 1'b0;
      end else begin
         shift_reg <= next_shift_reg;
         word_hold <= next_word_hold;
         cap_toggle <= next_cap_toggle;
      end
   end

   // launch on rising edge so the host samples a settled bit
   always_comb begin
      next_so_bit = shift_reg[23];
   end

   always_ff @(posedge sclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         so_bit <= 1'b0;
         daisy_m <= 1'b0;
         daisy_s <= 1'b0;
         rb_m <= 1'b0;
         rb_s <= 1'b0;
      end else begin
         so_bit <= next_so_bit;
         daisy_m <= daisy_chain_en_in;
         daisy_s <= daisy_m;
         rb_m <= readback_en_in;
         rb_s <= rb_m;
      end
   end

   // mode levels only settle once the serial clock has run twice
   assign serial_out_en_out = daisy_s || rb_s;
   assign serial_out_out = serial_out_en_out ? so_bit : 1'b0;

   // system domain: pins and the capture toggle arrive through synchronisers
   logic [SYNC_BITS-1:0] sync_raw, sync_q;
   logic frame_hi, tog_s, ld_n_s, clr_n_s;
   dspcp_fault_type fault_s;
   logic tog_prev, ld_prev, clr_prev;
   logic next_tog_prev, next_ld_prev, next_clr_prev;
   logic pending, next_pending;
   logic cap_evt, ld_fall, clr_evt;
   logic push_valid, push_ready, pop_valid, pop_ready;
   logic [23:0] pop_raw;
   dspcp_frame_type pop_word;
   logic [15:0] in_reg, next_in_reg, out_reg, next_out_reg;
   dspcp_clear_sel_type clear_sel, next_clear_sel;
   dspcp_upd_state_type upd_state, next_upd_state;
   logic alert_hold, next_alert_hold, next_alert_n;
   logic pop_write, pop_ctrl;

   assign sync_raw = {frame_sel_n_in, cap_toggle, load_strobe_n_in,
      clear_n_in, fault_in};

   dspcp_sync #(.WIDTH(SYNC_BITS)) u_sync (
      .clk_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .d_in(sync_raw),
      .q_out(sync_q)
   );

   assign {frame_hi, tog_s, ld_n_s, clr_n_s, fault_s} = sync_q;

   // edge detection on synchronised levels only
   assign cap_evt = (tog_s != tog_prev);
   assign ld_fall = ld_prev && !ld_n_s;
   assign clr_evt = clr_prev && !clr_n_s;

   // word waits until frame select is back high; set wins over clear
   assign push_valid = pending && frame_hi;
   always_comb begin
      next_tog_prev = tog_s;
      next_ld_prev = ld_n_s;
      next_clr_prev = clr_n_s;
      next_pending = cap_evt || (pending && !(push_valid && push_ready));
   end

   // history starts low like the synchroniser, so release fakes no edge
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tog_prev <= 1'b0;
         ld_prev <= 1'b0;
         clr_prev <= 1'b0;
         pending <= 1'b0;
      end else begin
         tog_prev <= next_tog_prev;
         ld_prev <= next_ld_prev;
         clr_prev <= next_clr_prev;
         pending <= next_pending;
      end
   end

   // word_hold is static for many cycles once the toggle has crossed
   dspcp_fifo #(.WIDTH(FRAME_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .wr_valid_in(push_valid),
      .wr_ready_out(push_ready),
      .wr_data_in(word_hold),
      .rd_valid_out(pop_valid),
      .rd_ready_in(pop_ready),
      .rd_data_out(pop_raw)
   );

   // a clear edge owns the output register, so decoding stalls
   assign pop_ready = !clr_evt;
   assign pop_word = pop_raw;
   assign pop_write = pop_valid && pop_ready && pop_word.cmd == CMD_WRITE_INPUT;
   assign pop_ctrl = pop_valid && pop_ready && pop_word.cmd == CMD_WRITE_CTRL;

   // update and clear control
   always_comb begin
      next_in_reg = in_reg;
      next_out_reg = out_reg;
      next_upd_state = upd_state;
      next_clear_sel = clear_sel;
      next_alert_hold = alert_hold;
      if (pop_ctrl) begin
         next_clear_sel = dspcp_clear_sel_type'(pop_word.data[CLR_SEL_POS +: 2]);
         next_alert_hold = 1'b0;
      end
      case (upd_state)
         UPD_IDLE: begin
            if (pop_write && !ld_n_s) begin
               next_out_reg = pop_word.data;
            end else if (pop_write) begin
               next_upd_state = UPD_HELD;
            end
         end
         UPD_HELD: begin
            if (ld_fall) begin
               next_out_reg = in_reg;
               next_upd_state = UPD_IDLE;
            end
         end
         default: begin
            next_upd_state = UPD_IDLE;
         end
      endcase
      if (pop_write) begin
         next_in_reg = pop_word.data;
      end
      if (clr_evt) begin
         case (clear_sel)
            CLR_MID: next_out_reg = CODE_MID;
            CLR_FULL: next_out_reg = CODE_FULL;
            default: next_out_reg = CODE_ZERO;
         endcase
      end
      next_alert_n = !(alert_hold || (|fault_s));
   end

   // reset restores power-on defaults with the output clamped
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         in_reg <= CODE_RESET;
         out_reg <= CODE_RESET;
         upd_state <= UPD_IDLE;
         clear_sel <= CLR_ZERO;
         alert_hold <= 1'b1;
         alert_n_out <= 1'b0;
      end else begin
         in_reg <= next_in_reg;
         out_reg <= next_out_reg;
         upd_state <= next_upd_state;
         clear_sel <= next_clear_sel;
         alert_hold <= next_alert_hold;
         alert_n_out <= next_alert_n;
      end
   end

   assign dac_code_out = out_reg;
   assign input_code_out = in_reg;
   assign out_clamp_out = alert_hold;

   // checks
   so_launch_a: assert property (@(negedge sclk_in) disable iff (!rst_n_in)
      serial_out_en_out |-> serial_out_out == shift_reg[23])
      else $error("serial output bit not launched from shift msb");
   so_enable_a: assert property (@(posedge sclk_in) disable iff (!rst_n_in)
      (!daisy_chain_en_in && !readback_en_in) [*2]
      |=> !serial_out_en_out && !serial_out_out)
      else $error("serial output active outside chain or readback");
   shift_in_a: assert property (@(negedge sclk_in) disable iff (!rst_n_in)
      !frame_sel_n_in |=> shift_reg[0] == $past(serial_in_in))
      else $error("input bit not shifted on falling edge");
   frame_len_a: assert property (@(negedge sclk_in) disable iff (!rst_n_in)
      !frame_sel_n_in && bit_cnt == BIT_CNT_FULL - 5'h01
      |=> cap_toggle != $past(cap_toggle))
      else $error("word captured at wrong bit count");
   frame_act_a: assert property (@(posedge clk_sys_in)
      disable iff (!rst_n_in)
      $rose(pop_valid) |-> frame_hi && $past(frame_hi))
      else $error("frame acted on while frame select low");
   direct_load_a: assert property (@(posedge clk_sys_in)
      disable iff (!rst_n_in)
      pop_write && !ld_n_s && !clr_evt && upd_state == UPD_IDLE
      |=> out_reg == $past(pop_word.data))
      else $error("output register missed direct update");
   held_load_a: assert property (@(posedge clk_sys_in)
      disable iff (!rst_n_in)
      pop_write && ld_n_s && !clr_evt && upd_state == UPD_IDLE
      |=> out_reg == $past(out_reg) && upd_state == UPD_HELD)
      else $error("output register changed while strobe high");
   strobe_load_a: assert property (@(posedge clk_sys_in)
      disable iff (!rst_n_in)
      upd_state == UPD_HELD && ld_fall && !clr_evt
      |=> out_reg == $past(in_reg))
      else $error("strobe fall did not transfer input register");
   clear_code_a: assert property (@(posedge clk_sys_in)
      disable iff (!rst_n_in)
      clr_evt |=> out_reg == (($past(clear_sel) == CLR_MID) ? CODE_MID :
         ($past(clear_sel) == CLR_FULL) ? CODE_FULL : CODE_ZERO))
      else $error("clear edge loaded wrong code");
   fault_alert_a: assert property (@(posedge clk_sys_in)
      disable iff (!rst_n_in)
      (|fault_s) |=> !alert_n_out)
      else $error("alert not asserted on fault");
   alert_release_a: assert property (@(posedge clk_sys_in)
      disable iff (!rst_n_in)
      $rose(alert_n_out) |-> $past(!alert_hold, 1))
      else $error("alert released before control write");
   reset_state_a: assert property (@(posedge clk_sys_in)
      disable iff (!rst_n_in)
      $past(!rst_n_in) |-> out_clamp_out && out_reg == CODE_RESET)
      else $error("defaults not restored after reset");
endmodule
`default_nettype wire

// ### dspcp_pkg.sv
// constants and carrier types for the converter serial port and control pins
// Functional notes
// - serial output changes on rising serial clock
// - serial output driven only in chain/readback modes
// - load strobe low: input write also updates output
// - load strobe high: update waits for strobe fall
// - frame select low: one bit per falling edge
// - frame is acted on when frame select rises
// - alert low on overtemperature, short or brownout
// - alert low after reset until control write
// - clear falling edge loads selected clear code
// - reset restores defaults, output clamped and off
// - every frame is a 24-bit word
package dspcp_pkg;
   localparam int FRAME_BITS = 24;
   localparam int CODE_BITS = 16;
   localparam int SCLK_MAX_MHZ = 50;
   localparam int FIFO_DEPTH = 2;
   localparam int SYNC_BITS = 7;
   localparam logic [4:0] BIT_CNT_RESET = 5'h00;
   localparam logic [4:0] BIT_CNT_FULL = 5'h18;
   localparam logic [3:0] CMD_WRITE_INPUT = 4'h1;
   localparam logic [3:0] CMD_WRITE_CTRL = 4'h4;
   localparam int CLR_SEL_POS = 0;
   localparam logic [15:0] CODE_ZERO = 16'h0000;
   localparam logic [15:0] CODE_MID = 16'h8000;
   localparam logic [15:0] CODE_FULL = 16'hffff;
   localparam logic [15:0] CODE_RESET = 16'h0000;
   localparam logic [23:0] WORD_RESET = 24'h000000;

   typedef enum logic [1:0] {
      CLR_ZERO,
      CLR_MID,
      CLR_FULL
   } dspcp_clear_sel_type;

   typedef enum logic {
      UPD_IDLE,
      UPD_HELD
   } dspcp_upd_state_type;

   typedef struct packed {
      logic [3:0] spare;
      logic [3:0] cmd;
      logic [15:0] data;
   } dspcp_frame_type;

   typedef struct packed {
      logic overtemp;
      logic short_circuit;
      logic brownout;
   } dspcp_fault_type;
endpackage

// ### dspcp_sync.sv
// two-stage synchroniser for a bundle of levels
`timescale 1ns/1ns
`default_nettype none
module dspcp_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // levels
   input wire logic [WIDTH-1:0] d_in,
   output logic [WIDTH-1:0] q_out
);
   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] next_meta;
   logic [WIDTH-1:0] next_q;

   // first stage feeds only the second
   always_comb begin
      next_meta = d_in;
      next_q = meta;
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meta <= '0;
         q_out <= '0;
      end else begin
         meta <= next_meta;
         q_out <= next_q;
      end
   end
endmodule
`default_nettype wire

// ### dspcp_fifo.sv
// small valid/ready buffer for received frames
`timescale 1ns/1ns
`default_nettype none
module dspcp_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 2
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // fill side
   input wire logic wr_valid_in,
   output logic wr_ready_out,
   input wire logic [WIDTH-1:0] wr_data_in,
   // drain side
   output logic rd_valid_out,
   input wire logic rd_ready_in,
   output logic [WIDTH-1:0] rd_data_out
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [CW-1:0] count, next_count;
   logic push, pop;

   // honest flags from the occupancy count
   assign wr_ready_out = (count != CW'(DEPTH));
   assign rd_valid_out = (count != '0);
   assign rd_data_out = mem[rd_ptr];
   assign push = wr_valid_in && wr_ready_out;
   assign pop = rd_valid_out && rd_ready_in;

   always_comb begin
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_count = count;
      if (push) begin
         next_wr_ptr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
         next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
         next_count = count + 1'b1;
      end else if (pop && !push) begin
         next_count = count - 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
   end

   // storage needs no reset; count guards every read
   always_ff @(posedge clk_in) begin
      if (push) begin
         mem[wr_ptr] <= wr_data_in;
      end
   end
endmodule
`default_nettype wire

// ### dspcp_host_model.sv
// host serial port model driving the converter's four-wire link
`timescale 1ns/1ns
`default_nettype none
module dspcp_host_model (
   // link outputs to the device
   output logic sclk_out,
   output logic frame_sel_n_out,
   output logic data_to_dev_out,
   // data returned by the device
   input wire logic data_from_dev_in
);
   logic [23:0] rx_word;

   // idle: clock stands still high between frames
   initial begin
      sclk_out = 1'b1;
      frame_sel_n_out = 1'b1;
      data_to_dev_out = 1'b1;
      rx_word = 24'h000000;
   end

   // msb first; fewer than 24 bits only to provoke a refusal
   task automatic send_frame(input logic [23:0] word, input int nbits);
      #13;
      frame_sel_n_out = 1'b0;
      for (int i = 23; i > 23 - nbits; i--) begin
         data_to_dev_out = word[i];
         #32 sclk_out = 1'b0;
         rx_word = {rx_word[22:0], data_from_dev_in};
         #32 sclk_out = 1'b1;
      end
      #32 frame_sel_n_out = 1'b1;
      // released line shows the inverse, not a stale bit
      data_to_dev_out = ~data_to_dev_out;
   endtask
endmodule
`default_nettype wire

// ### testbench.sv
// self-checking bench for the converter serial port and control pins
`timescale 1ns/1ns
`default_nettype none
module testbench
   import dspcp_pkg::*;
();
   typedef struct packed {
      logic [23:0] frame;
      logic [15:0] exp_input;
      logic [15:0] exp_dac;
      logic exp_alert_n;
   } dspcp_row_type;
   logic clk_sys_in, rst_n_in, sclk, frame_sel_n, ser_to_dev, ser_from_dev;
   logic ser_en, daisy_en, readback_en, load_n, clear_n, clamp, alert_n;
   dspcp_fault_type fault;
   logic [15:0] dac_code, input_code;
   logic [15:0] clear_codes [3] = '{CODE_ZERO, CODE_MID, CODE_FULL};
   dspcp_row_type rows [4];
   int bad_count = 0;
   int checks_done = 0;

   dspcp_core dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
      .sclk_in(sclk), .frame_sel_n_in(frame_sel_n),
      .serial_in_in(ser_to_dev), .serial_out_out(ser_from_dev),
      .serial_out_en_out(ser_en), .daisy_chain_en_in(daisy_en),
      .readback_en_in(readback_en), .load_strobe_n_in(load_n),
      .clear_n_in(clear_n), .fault_in(fault), .dac_code_out(dac_code),
      .input_code_out(input_code), .out_clamp_out(clamp),
      .alert_n_out(alert_n));

   dspcp_host_model host (.sclk_out(sclk), .frame_sel_n_out(frame_sel_n),
      .data_to_dev_out(ser_to_dev), .data_from_dev_in(ser_from_dev));

   // 25 MHz system clock
   initial begin
      clk_sys_in = 1'b0;
      forever #20 clk_sys_in = ~clk_sys_in;
   end

   task automatic check_val(input logic [23:0] got, input logic [23:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic end_test(input string name);
      $display("test %s done, mismatches so far %0d", name, bad_count);
   endtask

   // decode lands on the 4th clock edge after select rises; 12 leaves margin
   task automatic frame(input logic [23:0] w, input int n);
      @(negedge clk_sys_in);
      host.send_frame(w, n);
      repeat (12) @(negedge clk_sys_in);
   endtask

   // bounded wait for the output register to reach a value
   task automatic wait_dac(input logic [15:0] exp);
      for (int i = 0; i < 20 && dac_code !== exp; i++)
         @(negedge clk_sys_in);
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // cut a hang short; the whole run needs well under this
   initial begin
      #300000;
      bad_count++;
      report_and_stop();
   end

   initial begin
      rst_n_in = 1'b0;
      daisy_en = 1'b0;
      readback_en = 1'b0;
      load_n = 1'b1;
      clear_n = 1'b1;
      fault = '0;
      rows[0] = '{{4'h0, CMD_WRITE_INPUT, 16'h1234}, 16'h1234, 16'h1234, 1'b0};
      rows[1] = '{{4'h0, CMD_WRITE_CTRL, 16'h0001}, 16'h1234, 16'h1234, 1'b1};
      rows[2] = '{{4'h0, CMD_WRITE_INPUT, 16'hffff}, 16'hffff, 16'hffff, 1'b1};
      rows[3] = '{{4'h0, CMD_WRITE_INPUT, 16'h0000}, 16'h0000, 16'h0000, 1'b1};
      repeat (12) @(negedge clk_sys_in);
      check_val(dac_code, CODE_RESET);
      check_val(input_code, CODE_RESET);
      check_val(clamp, 1'b1);
      check_val(alert_n, 1'b0);
      check_val(ser_en, 1'b0);
      rst_n_in = 1'b1;
      repeat (3) @(negedge clk_sys_in);
      load_n = 1'b0;
      end_test("reset");
      // ordinary writes with the load strobe tied low
      foreach (rows[i]) begin
         frame(rows[i].frame, 24);
         check_val(input_code, rows[i].exp_input);
         check_val(dac_code, rows[i].exp_dac);
         check_val(alert_n, rows[i].exp_alert_n);
      end
      check_val(host.rx_word, 24'h000000);
      check_val(clamp, 1'b0);
      end_test("rows");
      // held update: latest input loads on strobe fall
      load_n = 1'b1;
      repeat (4) @(negedge clk_sys_in);
      frame({4'h0, CMD_WRITE_INPUT, 16'h5555}, 24);
      check_val(input_code, 16'h5555);
      frame({4'h0, CMD_WRITE_INPUT, 16'h6666}, 24);
      check_val(dac_code, 16'h0000);
      load_n = 1'b0;
      wait_dac(16'h6666);
      check_val(dac_code, 16'h6666);
      end_test("held_update");
      // every clear selection
      for (int s = 0; s < 3; s++) begin
         frame({4'h0, CMD_WRITE_INPUT, 16'h4321}, 24);
         frame({4'h0, CMD_WRITE_CTRL, 14'h0000, s[1:0]}, 24);
         clear_n = 1'b0;
         wait_dac(clear_codes[s]);
         check_val(dac_code, clear_codes[s]);
         clear_n = 1'b1;
         repeat (4) @(negedge clk_sys_in);
      end
      end_test("clear");
      // each fault source pulls the alert low
      for (int f = 0; f < 3; f++) begin
         fault = dspcp_fault_type'(3'h4 >> f);
         repeat (8) @(negedge clk_sys_in);
         check_val(alert_n, 1'b0);
         fault = '0;
         frame({4'h0, CMD_WRITE_CTRL, 16'h0000}, 24);
         check_val(alert_n, 1'b1);
      end
      end_test("alert");
      frame({4'h0, CMD_WRITE_INPUT, 16'h0bad}, 16);
      check_val(input_code, 16'h4321);
      end_test("short_frame");
      // chain: second frame returns the first one
      daisy_en = 1'b1;
      frame({4'h0, CMD_WRITE_INPUT, 16'hc3a5}, 24);
      check_val(ser_en, 1'b1);
      frame({4'h0, CMD_WRITE_INPUT, 16'h5a3c}, 24);
      check_val(host.rx_word, {4'h0, CMD_WRITE_INPUT, 16'hc3a5});
      daisy_en = 1'b0;
      readback_en = 1'b1;
      frame({4'h0, CMD_WRITE_INPUT, 16'h0f0f}, 24);
      check_val(ser_en, 1'b1);
      end_test("chain");
      // mid-run reset: defaults return, release fakes no pin edge
      @(negedge clk_sys_in);
      rst_n_in = 1'b0;
      repeat (2) @(negedge clk_sys_in);
      check_val(dac_code, CODE_RESET);
      check_val(input_code, CODE_RESET);
      check_val(clamp, 1'b1);
      check_val(ser_en, 1'b0);
      rst_n_in = 1'b1;
      repeat (4) @(negedge clk_sys_in);
      check_val(alert_n, 1'b0);
      check_val(dac_code, CODE_RESET);
      end_test("reset_again");
      report_and_stop();
   end
endmodule
`default_nettype wire
